// [core/ccd_sync_regs.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef CCD_SYNC_REGS_SVH
`define CCD_SYNC_REGS_SVH

// ----------------------------------------------------------------------
// Serial port framing
// ----------------------------------------------------------------------
`define SP_ADDR_W       10
`define SP_DATA_W       6
`define SP_ADDR_LAST    4'h9
`define SP_DATA_LAST    4'h5
`define SP_REG_AREA_END 10'h0BF

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_OUT_DELAY  10'h002
`define ADDR_EDGE_SEL   10'h020
`define ADDR_GATE_TIME  10'h021
`define ADDR_BUF_CLK    10'h022
`define ADDR_ODD_LIM    10'h02F
`define ADDR_LATENCY    10'h034

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EDGE_SYNC_BIT   3
`define EDGE_CLK_BIT    2
`define VERT_LIM_MSB    2
`define VERT_LIM_LSB    0
`define HORZ_LIM_MSB    5
`define HORZ_LIM_LSB    3
`define LAT_MSB         3
`define LAT_LSB         0
`define DLY_MSB         2
`define DLY_LSB         0
`define GATE_PH_MSB     2
`define GATE_PH_LSB     0
`define GATE_W_MSB      5
`define GATE_W_LSB      3
`define BUF_PH_MSB      1
`define BUF_PH_LSB      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_OUT_DELAY   6'h00
`define RST_EDGE_SEL    6'h00
`define RST_GATE_TIME   6'h10
`define RST_BUF_CLK     6'h00
`define RST_ODD_LIM     6'h09
`define RST_LATENCY     6'h06

// ----------------------------------------------------------------------
// Limits and master-mode timing, in clock cycles unless noted
// ----------------------------------------------------------------------
`define LIMIT_MAX       3'h6
`define DATA_DELAY_MAX_NS 3'h6
`define SINCE_SAT       3'h7
`define LINE_CYCLES     12'h0320
`define FRAME_LINES     12'h020D
`define HSYNC_CYCLES    12'h0040
`define VSYNC_LINES     12'h0003

`endif

// [core/ccd_sync_pkg.sv]
// Types shared by the sync block and its serial register port
package ccd_sync_pkg;

  typedef enum logic [2:0] {
    SP_IDLE = 3'b001,
    SP_ADDR = 3'b010,
    SP_DATA = 3'b100
  } spState_t;

  typedef struct packed {
    spState_t    state;
    logic [9:0]  addr;
    logic [5:0]  data;
    logic [3:0]  bitCnt;
    logic        full;
    logic        sclkPrev;
    logic        wrStb;
    logic [9:0]  wrAddr;
    logic [5:0]  wrData;
  } spRegs_t;

  typedef struct packed {
    logic        vPrev;
    logic        hPrev;
    logic [5:0]  regOutDelay;
    logic [5:0]  regEdgeSel;
    logic [5:0]  regGateTiming;
    logic [5:0]  regBufClk;
    logic [5:0]  regOddLim;
    logic [5:0]  regLatency;
    logic [2:0]  sinceV;
    logic [2:0]  sinceH;
    logic        oddField;
    logic [4:0]  latCnt;
    logic        hReset;
    logic [11:0] hCount;
    logic [11:0] lineCount;
    logic        vOut;
    logic        hOut;
    logic        oeN;
    logic [2:0]  dataOutDelay;
  } syncRegs_t;

endpackage : ccd_sync_pkg

// [core/serial_reg_port.sv]
// Three-wire serial receiver: 10-bit address then 6-bit data, LSB first
`include "ccd_sync_regs.svh"

module serial_reg_port (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       serialDataIn,
  input  wire logic       serialClk,
  input  wire logic       chipSelectN,
  output logic            wrStb,
  output logic [9:0]      wrAddr,
  output logic [5:0]      wrData
);

  ccd_sync_pkg::spRegs_t s;
  ccd_sync_pkg::spRegs_t next_s;
  logic                  sclkRise;

  localparam ccd_sync_pkg::spRegs_t SP_RESET = '{
    state: ccd_sync_pkg::SP_IDLE, addr: 10'h000, data: 6'h00,
    bitCnt: 4'h0, full: 1'b0, sclkPrev: 1'b0, wrStb: 1'b0,
    wrAddr: 10'h000, wrData: 6'h00};

  always_comb begin
    next_s          = s;
    next_s.wrStb    = 1'b0;
    next_s.sclkPrev = serialClk;
    sclkRise        = serialClk & ~s.sclkPrev;
    case (s.state)
      ccd_sync_pkg::SP_IDLE: begin
        if (!chipSelectN) begin
          next_s.state  = ccd_sync_pkg::SP_ADDR;
          next_s.bitCnt = 4'h0;
          next_s.full   = 1'b0;
        end
      end
      ccd_sync_pkg::SP_ADDR: begin
        if (chipSelectN) begin
          next_s.state = ccd_sync_pkg::SP_IDLE;
        end else if (sclkRise) begin
          next_s.addr = {serialDataIn, s.addr[9:1]}; // [RULE13]
          if (s.bitCnt == `SP_ADDR_LAST) begin
            next_s.state  = ccd_sync_pkg::SP_DATA;
            next_s.bitCnt = 4'h0;
          end else begin
            next_s.bitCnt = s.bitCnt + 4'h1;
          end
        end
      end
      ccd_sync_pkg::SP_DATA: begin
        if (chipSelectN) begin
          // Standard write lands on the rise of select; a partial word
          // is dropped
          next_s.state  = ccd_sync_pkg::SP_IDLE;
          next_s.wrStb  = s.full; // [RULE13]
          next_s.wrAddr = s.addr;
          next_s.wrData = s.data;
        end else if (sclkRise) begin
          next_s.data = {serialDataIn, s.data[5:1]};
          if (s.full) begin
            // More bits after a full word: continuous write, next address
            next_s.wrStb  = 1'b1; // [RULE13]
            next_s.wrAddr = s.addr;
            next_s.wrData = s.data;
            next_s.addr   = s.addr + 10'h001;
            next_s.full   = 1'b0;
            next_s.bitCnt = 4'h1;
          end else if (s.bitCnt == `SP_DATA_LAST) begin
            next_s.full   = 1'b1;
            next_s.bitCnt = 4'h0;
          end else begin
            next_s.bitCnt = s.bitCnt + 4'h1;
          end
        end
      end
      default: begin
        next_s.state = ccd_sync_pkg::SP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= SP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign wrStb  = s.wrStb;
  assign wrAddr = s.wrAddr;
  assign wrData = s.wrData;

endmodule : serial_reg_port

// [core/ccd_sync_detect_hcounter.sv]
// Sync detection, odd-field flag, pixel counter and phase settings
`include "ccd_sync_regs.svh"

// Functional notes
// RULE1 - In slave mode sample both sync inputs every rising clock edge.
// RULE2 - Flag odd or first field from vertical versus horizontal edge phase.
// RULE3 - Vertical trailing-edge tolerance 0..6 cycles, three-bit field, default 1.
// RULE4 - Horizontal trailing-edge tolerance 0..6 cycles, three-bit field, default 1.
// RULE5 - Selected horizontal sync edge resets the pixel counter.
// RULE6 - One bit picks sync edge, another picks the clock edge for reset; the clock-edge bit here adds one rising-edge cycle of latency instead.
// RULE7 - Four-bit latency from horizontal detection to counter reset, default 6.
// RULE8 - Output data delay register, 0 to 6 ns, default zero.
// RULE9 - Output buffer clock phase programmable in quarter-pixel steps.
// RULE10 - Reset gate pulse width is programmable.
// RULE11 - Reset gate pulse phase is programmable.
// RULE12 - In master mode drive both syncs, falling edges from rising clock.
// RULE13 - Settings arrive over three-wire serial: 10-bit address, 6-bit data.
// RULE14 - Pixel counter advances by one every clock between resets.
// RULE15 - Far side keeps sync trailing edges at least ten cycles apart.
module ccd_sync_detect_hcounter (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       masterMode,
  input  wire logic       serialDataIn,
  input  wire logic       serialClk,
  input  wire logic       chipSelectN,
  input  wire logic       verticalSyncPinIn,
  output logic            verticalSyncPinOut,
  output logic            verticalSyncPinOeN,
  input  wire logic       horizontalSyncPinIn,
  output logic            horizontalSyncPinOut,
  output logic            horizontalSyncPinOeN,
  output logic            oddField,
  output logic [11:0]     hCount,
  output logic            hCountReset,
  output logic [2:0]      dataOutDelay,
  output logic [1:0]      bufClkPhase,
  output logic [2:0]      resetGatePhase,
  output logic [2:0]      resetGateWidth
);

  ccd_sync_pkg::syncRegs_t s;
  ccd_sync_pkg::syncRegs_t next_s;

  logic       wrStb;
  logic [9:0] wrAddr;
  logic [5:0] wrData;
  logic       vEdge;
  logic       hEdge;
  logic [2:0] vertLimit;
  logic [2:0] horzLimit;
  logic [4:0] effLatency;
  logic       lineEnd;

  localparam ccd_sync_pkg::syncRegs_t SYNC_RESET = '{
    vPrev: 1'b1, hPrev: 1'b1,
    regOutDelay: `RST_OUT_DELAY, regEdgeSel: `RST_EDGE_SEL,
    regGateTiming: `RST_GATE_TIME, regBufClk: `RST_BUF_CLK,
    regOddLim: `RST_ODD_LIM, regLatency: `RST_LATENCY,
    sinceV: `SINCE_SAT, sinceH: `SINCE_SAT, oddField: 1'b0,
    latCnt: 5'h00, hReset: 1'b0, hCount: 12'h000, lineCount: 12'h000,
    vOut: 1'b1, hOut: 1'b1, oeN: 1'b1, dataOutDelay: 3'h0};

  // ----------------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------------
  serial_reg_port u_port (
    .core_clk     (core_clk),
    .reset        (reset),
    .serialDataIn (serialDataIn),
    .serialClk    (serialClk),
    .chipSelectN  (chipSelectN),
    .wrStb        (wrStb),
    .wrAddr       (wrAddr),
    .wrData       (wrData)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Register writes; addresses outside this block are ignored
    if (wrStb && wrAddr <= `SP_REG_AREA_END) begin
      case (wrAddr)
        `ADDR_OUT_DELAY: next_s.regOutDelay = wrData; // [RULE8]
        `ADDR_EDGE_SEL:  next_s.regEdgeSel  = wrData; // [RULE6]
        `ADDR_GATE_TIME: next_s.regGateTiming = wrData; // [RULE10] [RULE11]
        `ADDR_BUF_CLK:   next_s.regBufClk   = wrData; // [RULE9]
        `ADDR_ODD_LIM:   next_s.regOddLim   = wrData; // [RULE3] [RULE4]
        `ADDR_LATENCY:   next_s.regLatency  = wrData; // [RULE7]
        default: begin
        end
      endcase
    end

    // Delay beyond 6 ns is not reachable; clamp rather than wrap
    if (s.regOutDelay[`DLY_MSB:`DLY_LSB] > `DATA_DELAY_MAX_NS) begin
      next_s.dataOutDelay = `DATA_DELAY_MAX_NS; // [RULE8]
    end else begin
      next_s.dataOutDelay = s.regOutDelay[`DLY_MSB:`DLY_LSB];
    end

    // Tolerance fields saturate at 6 cycles
    vertLimit = s.regOddLim[`VERT_LIM_MSB:`VERT_LIM_LSB]; // [RULE3]
    if (vertLimit > `LIMIT_MAX) begin
      vertLimit = `LIMIT_MAX;
    end
    horzLimit = s.regOddLim[`HORZ_LIM_MSB:`HORZ_LIM_LSB]; // [RULE4]
    if (horzLimit > `LIMIT_MAX) begin
      horzLimit = `LIMIT_MAX;
    end

    // Trailing-edge detection on the sampled pins
    next_s.vPrev = verticalSyncPinIn; // [RULE1]
    next_s.hPrev = horizontalSyncPinIn; // [RULE1]
    if (s.regEdgeSel[`EDGE_SYNC_BIT]) begin
      vEdge = verticalSyncPinIn & ~s.vPrev; // [RULE6]
      hEdge = horizontalSyncPinIn & ~s.hPrev;
    end else begin
      vEdge = ~verticalSyncPinIn & s.vPrev; // [RULE6]
      hEdge = ~horizontalSyncPinIn & s.hPrev;
    end
    if (masterMode) begin
      vEdge = 1'b0;
      hEdge = 1'b0;
    end

    // Cycles since each edge, saturating so a stale edge never matches
    if (vEdge) begin
      next_s.sinceV = 3'h0;
    end else if (s.sinceV != `SINCE_SAT) begin
      next_s.sinceV = s.sinceV + 3'h1;
    end
    if (hEdge) begin
      next_s.sinceH = 3'h0;
    end else if (s.sinceH != `SINCE_SAT) begin
      next_s.sinceH = s.sinceH + 3'h1;
    end

    // Field decision: vertical edge opens a field, a nearby horizontal
    // edge on either side marks it odd. A late vertical edge is held to
    // the vertical limit, a late horizontal edge to the horizontal one
    if (vEdge) begin
      next_s.oddField = hEdge || (s.sinceH < vertLimit); // [RULE2] [RULE3]
    end else if (hEdge && s.sinceV < horzLimit) begin
      next_s.oddField = 1'b1; // [RULE2] [RULE4]
    end

    // Counter reset latency; a falling clock-edge choice costs one cycle
    // since only the rising edge exists here
    effLatency = {1'b0, s.regLatency[`LAT_MSB:`LAT_LSB]}
               + {4'h0, s.regEdgeSel[`EDGE_CLK_BIT]}; // [RULE6] [RULE7]
    next_s.hReset = 1'b0;
    if (hEdge) begin
      if (effLatency == 5'h00) begin
        next_s.hReset = 1'b1; // [RULE5]
        next_s.latCnt = 5'h00;
      end else begin
        next_s.latCnt = effLatency; // [RULE7]
      end
    end else if (s.latCnt != 5'h00) begin
      next_s.latCnt = s.latCnt - 5'h01;
      next_s.hReset = (s.latCnt == 5'h01); // [RULE7]
    end

    // Pixel counter
    lineEnd = masterMode && (s.hCount >= `LINE_CYCLES - 12'h001);
    if (next_s.hReset || lineEnd) begin
      next_s.hCount = 12'h000; // [RULE5]
    end else begin
      next_s.hCount = s.hCount + 12'h001; // [RULE14]
    end

    // Master mode sync generation, registered so both falling edges
    // leave on a rising clock edge
    next_s.oeN = ~masterMode; // [RULE12]
    if (masterMode) begin
      if (lineEnd) begin
        if (s.lineCount >= `FRAME_LINES - 12'h001) begin
          next_s.lineCount = 12'h000;
        end else begin
          next_s.lineCount = s.lineCount + 12'h001;
        end
      end
      next_s.hOut = ~(next_s.hCount < `HSYNC_CYCLES); // [RULE12]
      next_s.vOut = ~(next_s.lineCount < `VSYNC_LINES); // [RULE12]
    end else begin
      next_s.lineCount = 12'h000;
      next_s.hOut      = 1'b1;
      next_s.vOut      = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s <= SYNC_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign verticalSyncPinOut   = s.vOut;
  assign verticalSyncPinOeN   = s.oeN;
  assign horizontalSyncPinOut = s.hOut;
  assign horizontalSyncPinOeN = s.oeN;
  assign oddField             = s.oddField;
  assign hCount               = s.hCount;
  assign hCountReset          = s.hReset;
  assign dataOutDelay         = s.dataOutDelay;
  assign bufClkPhase          = s.regBufClk[`BUF_PH_MSB:`BUF_PH_LSB];
  assign resetGatePhase       = s.regGateTiming[`GATE_PH_MSB:`GATE_PH_LSB];
  assign resetGateWidth       = s.regGateTiming[`GATE_W_MSB:`GATE_W_LSB];

endmodule : ccd_sync_detect_hcounter

// [tb/sync_line.sv]
// Image processor model driving one sync line in slave mode
module sync_line (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic trailRise,
  input  wire logic fire,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] left;
  logic [4:0] gap;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      left <= 3'h0;
      gap  <= 5'h1f;
    end else if (fire && left == 3'h0 && gap >= 5'h0a) begin
      left <= 3'h4;
      gap  <= 5'h00;
    end else begin
      left <= (left == 3'h0) ? left : left - 3'h1;
      gap  <= (gap == 5'h1f) ? gap : gap + 5'h01;
    end
  end
  // Trailing edge opens the pulse, so the idle level is its inverse
  assign line = (left != 3'h0) ? trailRise : ~trailRise;
endmodule : sync_line

// [tb/ccd_sync_properties.sv]
// Port-level checks for the sync detection block
module ccd_sync_properties (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        masterMode,
  input wire logic        chipSelectN,
  input wire logic        horizontalSyncPinIn,
  input wire logic        horizontalSyncPinOut,
  input wire logic        horizontalSyncPinOeN,
  input wire logic        verticalSyncPinOeN,
  input wire logic [11:0] hCount,
  input wire logic        hCountReset,
  input wire logic [2:0]  dataOutDelay,
  input wire logic [1:0]  bufClkPhase
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------
  // Cycles since the horizontal pin last moved, saturating
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       prev;
    logic [4:0] since;
  } chk_t;
  chk_t cur;
  chk_t next_cur;
  always_comb begin
    next_cur.prev  = horizontalSyncPinIn;
    next_cur.since = (cur.since == 5'h1f) ? cur.since : cur.since + 5'h01;
    if (reset)
      next_cur.since = 5'h1f;
    else if (horizontalSyncPinIn != cur.prev)
      next_cur.since = 5'h00;
  end
  always_ff @(posedge core_clk) cur <= next_cur;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_oen_master: assert property (!$past(reset) && $past(masterMode)
    |-> !horizontalSyncPinOeN && !verticalSyncPinOeN)
    else $error("sync pins not driven in master mode");
  a_slave_release: assert property (!$past(masterMode)
    |-> horizontalSyncPinOeN && verticalSyncPinOeN && horizontalSyncPinOut)
    else $error("sync pins driven in slave mode");
  a_hsync_width: assert property ($past(masterMode, 2) && $past(masterMode)
    |-> horizontalSyncPinOut == (hCount >= 12'h0040))
    else $error("master horizontal sync width wrong");
  a_count_step: assert property (!$past(reset) && !$past(masterMode)
    && !hCountReset |-> hCount == $past(hCount) + 12'h0001)
    else $error("pixel counter did not advance by one");
  a_reset_pulse: assert property (hCountReset
    |-> hCount == 12'h0000 ##1 !hCountReset && hCount == 12'h0001)
    else $error("counter reset pulse wrong");
  a_master_noreset: assert property (masterMode && $past(masterMode)
    && $past(masterMode, 20) |-> !hCountReset)
    else $error("sync input reset counter in master mode");
  a_latency_bound: assert property (hCountReset |-> cur.since <= 5'h11)
    else $error("counter reset too long after sync edge");
  a_delay_range: assert property (dataOutDelay <= 3'h6)
    else $error("data delay above six");
  a_setting_hold: assert property (chipSelectN [*5]
    |-> $stable({dataOutDelay, bufClkPhase}))
    else $error("setting changed without serial write");
endmodule : ccd_sync_properties

bind ccd_sync_detect_hcounter ccd_sync_properties i_props (
  .core_clk(core_clk), .reset(reset), .masterMode(masterMode),
  .chipSelectN(chipSelectN), .horizontalSyncPinIn(horizontalSyncPinIn),
  .horizontalSyncPinOut(horizontalSyncPinOut),
  .horizontalSyncPinOeN(horizontalSyncPinOeN),
  .verticalSyncPinOeN(verticalSyncPinOeN), .hCount(hCount),
  .hCountReset(hCountReset), .dataOutDelay(dataOutDelay),
  .bufClkPhase(bufClkPhase));

// [tb/testbench.sv]
// Self-checking bench for the sync detection block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        masterMode = 1'b0;
  logic        sdi = 1'b0;
  logic        sclk = 1'b0;
  logic        csN = 1'b1;
  logic        trailRise = 1'b0;
  logic        fireH = 1'b0;
  logic        fireV = 1'b0;
  logic        hLine, vLine, hOut, vOut, hOeN, vOeN, oddField, hCountReset;
  logic        hSeen = 1'b1;
  logic        hOutSeen = 1'b1;
  logic [11:0] hCount;
  logic [2:0]  dly, gatePh, gateW;
  logic [1:0]  bufPh;
  wire logic   hPin = hOeN ? hLine : hOut;
  wire logic   vPin = vOeN ? vLine : vOut;
  int          failCount = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          edgeCyc = 0;
  int          delaySeen = 0;
  int          fallCyc = 0;
  int          fallGap = 0;
  logic [5:0]  latSel [6] = '{6'h00, 6'h00, 6'h00, 6'h04, 6'h08, 6'h0c};
  logic [5:0]  latVal [6] = '{6'h06, 6'h00, 6'h0f, 6'h06, 6'h03, 6'h00};
  logic [5:0]  oddLim [7] = '{6'h09, 6'h09, 6'h09, 6'h0b, 6'h0b, 6'h11, 6'h11};
  int          oddD [7] = '{0, 1, 2, 3, 4, -2, -3};
  logic        oddExp [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  always #5 core_clk = ~core_clk;

  ccd_sync_detect_hcounter i_dut (
    .core_clk(core_clk), .reset(reset), .masterMode(masterMode),
    .serialDataIn(sdi), .serialClk(sclk), .chipSelectN(csN),
    .verticalSyncPinIn(vPin), .verticalSyncPinOut(vOut),
    .verticalSyncPinOeN(vOeN), .horizontalSyncPinIn(hPin),
    .horizontalSyncPinOut(hOut), .horizontalSyncPinOeN(hOeN),
    .oddField(oddField), .hCount(hCount), .hCountReset(hCountReset),
    .dataOutDelay(dly), .bufClkPhase(bufPh), .resetGatePhase(gatePh),
    .resetGateWidth(gateW));
  sync_line i_hSrc (.core_clk(core_clk), .reset(reset),
    .trailRise(trailRise), .fire(fireH), .line(hLine));
  sync_line i_vSrc (.core_clk(core_clk), .reset(reset),
    .trailRise(trailRise), .fire(fireV), .line(vLine));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (failCount == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // LSB first, address then data; each serial clock phase spans two cycles
  task automatic sp_write(input logic [9:0] addr, input logic [5:0] data);
    logic [15:0] word;
    word = {data, addr};
    @(posedge core_clk);
    csN <= 1'b0;
    for (int b = 0; b < 16; b++) begin
      @(posedge core_clk);
      sdi <= word[b];
      sclk <= 1'b0;
      @(posedge core_clk);
      @(posedge core_clk);
      sclk <= 1'b1;
      @(posedge core_clk);
    end
    @(posedge core_clk);
    sclk <= 1'b0;
    csN <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : sp_write

  // Positive d: vertical edge d cycles after horizontal; negative: before
  task automatic pulse_pair(input int d);
    for (int i = 0; i <= ((d < 0) ? -d : d); i++) begin
      @(posedge core_clk);
      fireH <= (i == ((d < 0) ? -d : 0));
      fireV <= (i == ((d > 0) ? d : 0));
    end
    @(posedge core_clk);
    fireH <= 1'b0;
    fireV <= 1'b0;
  endtask : pulse_pair

  // --------------------------------------------------------------------
  // Edge timing monitor and hang guard
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (hPin !== hSeen && hPin === trailRise) edgeCyc = cyc;
    if (hCountReset === 1'b1) delaySeen = cyc - edgeCyc;
    if (hOutSeen === 1'b1 && hOut === 1'b0) begin
      fallGap = cyc - fallCyc;
      fallCyc = cyc;
    end
    hSeen = hPin;
    hOutSeen = hOut;
    if (cyc == 10000) begin
      failCount++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check(dly, 3'h0);
    check(bufPh, 2'h0);
    check({gateW, gatePh}, 6'h10);
    check({hOeN, vOeN, oddField}, 3'h6);
    sp_write(10'h002, 6'h05);
    check(dly, 3'h5);
    sp_write(10'h002, 6'h07);
    check(dly, 3'h6);
    sp_write(10'h022, 6'h03);
    check(bufPh, 2'h3);
    sp_write(10'h021, 6'h2b);
    check({gateW, gatePh}, 6'h2b);
    sp_write(10'h122, 6'h00);
    check(bufPh, 2'h3);
    for (int i = 0; i < 6; i++) begin
      trailRise <= latSel[i][3];
      sp_write(10'h020, latSel[i]);
      sp_write(10'h034, latVal[i]);
      delaySeen = -1;
      pulse_pair(0);
      repeat (30) @(posedge core_clk);
      check(delaySeen, latVal[i][3:0] + latSel[i][2] + 5'h01);
    end
    trailRise <= 1'b0;
    sp_write(10'h020, 6'h00);
    for (int i = 0; i < 7; i++) begin
      sp_write(10'h02f, oddLim[i]);
      pulse_pair(oddD[i]);
      repeat (12) @(posedge core_clk);
      check(oddField, oddExp[i]);
    end
    masterMode <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({hOeN, vOeN}, 2'h0);
    check(vOut, 1'b0);
    repeat (1700) @(posedge core_clk);
    check(fallGap, 32'h0000_0320);
    masterMode <= 1'b0;
    repeat (25) @(posedge core_clk);
    check({hOeN, vOeN, hOut, vOut}, 4'hf);
    conclude();
  end
endmodule : testbench
